/* rtl/mmiop_addr_latch.v */
// address latch: holds d while the latch enable is high, keeps it after;
// assumes d and le are synchronous to clk_i
`timescale 1ns/10ps
`include "mmiop_defines.vh"

module mmiop_addr_latch #(
   parameter W = 16
) (
   // clock, reset, enable
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   // latch
   input  wire         le_i,
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);

   // a registered latch rather than a real one keeps timing single-edge
   always @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= {W{1'b0}};
      end else if (ce_i && le_i) begin
         q_o <= d_i;
      end
   end

endmodule // mmiop_addr_latch

/* rtl/mmiop_defines.vh */
// constants for the five-port multi-mode i/o block: register indices,
// field widths and reset values; assumes one 100 mhz clock domain
//
// Functional notes
// - five independent eight-bit ports, A to E, each with several modes
// - every pin carries its own mode, so one port mixes functions
// - all port registers sit in one 256-word window picked by block select
// - control bit one hands the pin to register-driven standard i/o
// - standard output pin drives the stored data-out value when direction set
// - standard input pin: data-in read returns the pin level
// - pin keeps its role until its control bit is rewritten
// - logic mode: pin feeds the logic array or carries a macrocell output
// - logic-mode output floats whenever its product-term enable is low
// - logic mode is fixed configuration, active from reset, no write needed
// - address-out pins drive latched address bits 0 to 15
// - port A address inputs feed the decode array as extra address lines
// - program-memory decode takes extra address inputs from port A only
// - on a multiplexed bus port A address inputs latch on the strobe
// - ports C and D address inputs feed only general decoding
// - non-multiplexed bus: the data-port port serves as host data bus
// - control bits clear to zero on reset, selecting address-out
// - direction one is output; all inputs after reset; readable back
// - data-out register reads back the value last written
`ifndef MMIOP_DEFINES_VH
`define MMIOP_DEFINES_VH

`define MMIOP_NPORT      5
`define MMIOP_W          8
`define MMIOP_NPIN       40
`define MMIOP_ADDR_W     16

// word index within the window, taken from wishbone adr[9:2]
`define MMIOP_IDX_HI     9
`define MMIOP_IDX_LO     2

// register kinds, low nibble of the index with bit 0 cleared
`define MMIOP_K_DIN      4'h0
`define MMIOP_K_CTL      4'h2
`define MMIOP_K_DOUT     4'h4
`define MMIOP_K_DIR      4'h6
`define MMIOP_K_PLDIO    4'ha
`define MMIOP_K_MCO      4'hc

// index group (bits 5:4) and top bits that must be zero
`define MMIOP_GRP_AB     2'h0
`define MMIOP_GRP_CD     2'h1
`define MMIOP_GRP_E      2'h2
`define MMIOP_PORT_A     3'h0
`define MMIOP_PORT_B     3'h1
`define MMIOP_PORT_C     3'h2
`define MMIOP_PORT_D     3'h3
`define MMIOP_PORT_E     3'h4
`define MMIOP_PORT_NONE  3'h7

`define MMIOP_CTL_RST    8'h00
`define MMIOP_DIR_RST    8'h00
`define MMIOP_DOUT_RST   8'h00
`define MMIOP_BYTE_ZERO  8'h00
`define MMIOP_RD_PAD     24'h000000

`endif

/* rtl/mmiop_pin_mux.v */
// one eight-pin port: picks each pin's drive by its mode, registered;
// assumes mode, data and enables are synchronous to clk_i
`timescale 1ns/10ps
`include "mmiop_defines.vh"

module mmiop_pin_mux (
   // clock, reset, enable
   input  wire                 clk_i,
   input  wire                 rst_i,
   input  wire                 ce_i,
   // mode per pin
   input  wire [`MMIOP_W-1:0]  pld_i,
   input  wire [`MMIOP_W-1:0]  ctl_i,
   input  wire [`MMIOP_W-1:0]  dir_i,
   // sources
   input  wire [`MMIOP_W-1:0]  dout_i,
   input  wire [`MMIOP_W-1:0]  addr_i,
   input  wire [`MMIOP_W-1:0]  mc_i,
   input  wire [`MMIOP_W-1:0]  mc_oe_i,
   input  wire                 dp_en_i,
   input  wire [`MMIOP_W-1:0]  dp_dat_i,
   input  wire                 dp_oe_i,
   // pins
   output reg  [`MMIOP_W-1:0]  pin_o,
   output reg  [`MMIOP_W-1:0]  pin_oe_o
);

   reg [`MMIOP_W-1:0] o_nxt;
   reg [`MMIOP_W-1:0] oe_nxt;

   always @* begin
      if (dp_en_i) begin
         o_nxt  = dp_dat_i;
         oe_nxt = {`MMIOP_W{dp_oe_i}};
      end else begin
         // logic mode first, then control bit picks data-out or address
         o_nxt  = (pld_i & mc_i) | (~pld_i & ctl_i & dout_i)
                | (~pld_i & ~ctl_i & addr_i);
         oe_nxt = (pld_i & mc_oe_i) | (~pld_i & dir_i);
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         pin_o    <= `MMIOP_BYTE_ZERO;
         pin_oe_o <= `MMIOP_BYTE_ZERO;
      end else if (ce_i) begin
         pin_o    <= o_nxt;
         pin_oe_o <= oe_nxt;
      end
   end

endmodule // mmiop_pin_mux

/* rtl/mmiop_top.v */
// five-port multi-mode i/o block with a classic wishbone register slave;
// assumes the host decodes its base into io_block_select_i and that all
// inputs, pins included, are synchronous to clk_i
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
`include "mmiop_defines.vh"

module mmiop_top #(
   // logic-mode pins, one bit per pin, port a in bits 7:0
   parameter [`MMIOP_NPIN-1:0] PLD_MODE    = 40'h00_0000_0000,
   // host bus style: 1 multiplexed address/data, 0 separate buses
   parameter                   MUX_BUS     = 1'b1,
   // port c acts as host data port when the bus is not multiplexed
   parameter                   DATA_PORT_C = 1'b1
) (
   // clock, reset, enable
   input  wire                     clk_i,
   input  wire                     rst_i,
   input  wire                     ce_i,
   // wishbone slave
   input  wire                     cyc_i,
   input  wire                     stb_i,
   input  wire                     we_i,
   input  wire [31:0]              adr_i,
   input  wire [3:0]               sel_i,
   input  wire [31:0]              dat_i,
   output reg  [31:0]              dat_o,
   output reg                      ack_o,
   // window decode
   input  wire                     io_block_select_i,
   // multiplexed host bus
   input  wire [`MMIOP_ADDR_W-1:0] ad_i,
   input  wire                     address_latch_strobe_i,
   // non-multiplexed host data path
   input  wire [`MMIOP_W-1:0]      host_dat_i,
   input  wire                     host_dat_oe_i,
   output reg  [`MMIOP_W-1:0]      host_dat_o,
   // logic arrays
   input  wire [`MMIOP_NPIN-1:0]   gla_out_i,
   input  wire [`MMIOP_NPIN-1:0]   pla_oe_i,
   output reg  [`MMIOP_NPIN-1:0]   pla_in_o,
   output reg  [`MMIOP_W-1:0]      dla_addr_o,
   output reg  [2*`MMIOP_W-1:0]    pla_addr_o,
   // pins
   input  wire [`MMIOP_NPIN-1:0]   pin_i,
   output wire [`MMIOP_NPIN-1:0]   pin_o,
   output wire [`MMIOP_NPIN-1:0]   pin_oe_o
);

   // index decode, used for both read and write paths
   function [2:0] port_of;
      input [7:0] idx;
      begin
         if (idx[7:6] != 2'h0) begin
            port_of = `MMIOP_PORT_NONE;
         end else begin
            case (idx[5:4])
               `MMIOP_GRP_AB: port_of = idx[0] ? `MMIOP_PORT_B
                                               : `MMIOP_PORT_A;
               `MMIOP_GRP_CD: port_of = idx[0] ? `MMIOP_PORT_D
                                               : `MMIOP_PORT_C;
               `MMIOP_GRP_E:  port_of = idx[0] ? `MMIOP_PORT_NONE
                                               : `MMIOP_PORT_E;
               default:       port_of = `MMIOP_PORT_NONE;
            endcase
         end
      end
   endfunction

   function [3:0] kind_of;
      input [7:0] idx;
      begin
         kind_of = {idx[3:1], 1'b0};
      end
   endfunction

   // ports c and d carry no logic-status or macrocell registers
   function has_pld;
      input [2:0] p;
      begin
         has_pld = (p == `MMIOP_PORT_A) || (p == `MMIOP_PORT_B)
                || (p == `MMIOP_PORT_E);
      end
   endfunction

   // storage
   reg  [`MMIOP_NPIN-1:0] ctl_r;
   reg  [`MMIOP_NPIN-1:0] dir_r;
   reg  [`MMIOP_NPIN-1:0] dout_r;

   // bus decode
   wire [7:0] idx;
   wire [2:0] port;
   wire [3:0] kind;
   wire       req;
   wire       wr;
   wire       rd;

   assign idx  = adr_i[`MMIOP_IDX_HI:`MMIOP_IDX_LO];
   assign port = port_of(idx);
   assign kind = kind_of(idx);
   // one access per request; the ack cycle itself is not a new one
   assign req  = cyc_i & stb_i & ~ack_o;
   // outside the window the slave still acks, so the bus never hangs
   assign wr   = req & we_i & sel_i[0] & io_block_select_i;
   assign rd   = req & ~we_i & io_block_select_i;

   // write side, one generate slice per port
   genvar p;
   generate
      for (p = 0; p < `MMIOP_NPORT; p = p + 1) begin : g_reg
         always @(posedge clk_i) begin
            if (rst_i) begin
               ctl_r[p*`MMIOP_W +: `MMIOP_W]  <= `MMIOP_CTL_RST;
               dir_r[p*`MMIOP_W +: `MMIOP_W]  <= `MMIOP_DIR_RST;
               dout_r[p*`MMIOP_W +: `MMIOP_W] <= `MMIOP_DOUT_RST;
            end else if (ce_i && wr && (port == p)) begin
               case (kind)
                  `MMIOP_K_CTL:
                     ctl_r[p*`MMIOP_W +: `MMIOP_W] <= dat_i[7:0];
                  `MMIOP_K_DIR:
                     dir_r[p*`MMIOP_W +: `MMIOP_W] <= dat_i[7:0];
                  `MMIOP_K_DOUT:
                     dout_r[p*`MMIOP_W +: `MMIOP_W] <= dat_i[7:0];
                  default: begin
                     // read-only and unmapped kinds take no write
                     ctl_r[p*`MMIOP_W +: `MMIOP_W] <=
                        ctl_r[p*`MMIOP_W +: `MMIOP_W];
                  end
               endcase
            end
         end
      end
   endgenerate

   // read side
   reg  [`MMIOP_W-1:0] rd_nxt;
   wire [5:0]          sh;

   assign sh = {port, 3'h0};

   always @* begin
      rd_nxt = `MMIOP_BYTE_ZERO;
      if (port != `MMIOP_PORT_NONE) begin
         case (kind)
            `MMIOP_K_DIN:   rd_nxt = pin_i[sh +: `MMIOP_W];
            `MMIOP_K_CTL:   rd_nxt = ctl_r[sh +: `MMIOP_W];
            `MMIOP_K_DOUT:  rd_nxt = dout_r[sh +: `MMIOP_W];
            `MMIOP_K_DIR:   rd_nxt = dir_r[sh +: `MMIOP_W];
            `MMIOP_K_PLDIO: rd_nxt = has_pld(port)
                                   ? PLD_MODE[sh +: `MMIOP_W]
                                   : `MMIOP_BYTE_ZERO;
            `MMIOP_K_MCO:   rd_nxt = has_pld(port)
                                   ? gla_out_i[sh +: `MMIOP_W]
                                   : `MMIOP_BYTE_ZERO;
            default:        rd_nxt = `MMIOP_BYTE_ZERO;
         endcase
      end
   end

   // ack follows the request by one cycle and drops the cycle after
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= {`MMIOP_RD_PAD, `MMIOP_BYTE_ZERO};
      end else if (ce_i) begin
         ack_o <= req;
         if (rd) begin
            dat_o <= {`MMIOP_RD_PAD, rd_nxt};
         end else if (req) begin
            dat_o <= {`MMIOP_RD_PAD, `MMIOP_BYTE_ZERO};
         end
      end
   end

   // address-out latch from the multiplexed bus
   wire [`MMIOP_ADDR_W-1:0] ad_lat;

   mmiop_addr_latch #(
      .W (`MMIOP_ADDR_W)
   ) u_ad_lat (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .le_i  (address_latch_strobe_i),
      .d_i   (ad_i),
      .q_o   (ad_lat)
   );

   // port a address inputs: latched on the strobe only for a muxed bus
   wire              pa_le;
   wire [`MMIOP_W-1:0] pa_lat;

   assign pa_le = MUX_BUS ? address_latch_strobe_i : 1'b1;

   mmiop_addr_latch #(
      .W (`MMIOP_W)
   ) u_pa_lat (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .le_i  (pa_le),
      .d_i   (pin_i[`MMIOP_W-1:0]),
      .q_o   (pa_lat)
   );

   // array feeds, each from a flip-flop
   always @(posedge clk_i) begin
      if (rst_i) begin
         pla_in_o   <= {`MMIOP_NPIN{1'b0}};
         dla_addr_o <= `MMIOP_BYTE_ZERO;
         pla_addr_o <= {`MMIOP_BYTE_ZERO, `MMIOP_BYTE_ZERO};
         host_dat_o <= `MMIOP_BYTE_ZERO;
      end else if (ce_i) begin
         // every pin is visible to the logic array whatever its mode
         pla_in_o   <= pin_i;
         // only port a reaches program-memory decode
         dla_addr_o <= pa_lat;
         // ports c and d go unlatched to general decode only
         pla_addr_o <= pin_i[4*`MMIOP_W-1:2*`MMIOP_W];
         host_dat_o <= pin_i[3*`MMIOP_W-1:2*`MMIOP_W];
      end
   end

   // per-port pin drive
   wire dp_en;

   // data port needs separate buses; the far side wires address to ad_i
   assign dp_en = ~MUX_BUS & DATA_PORT_C;

   generate
      for (p = 0; p < `MMIOP_NPORT; p = p + 1) begin : g_port
         mmiop_pin_mux u_mux (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .ce_i     (ce_i),
            .pld_i    (PLD_MODE[p*`MMIOP_W +: `MMIOP_W]),
            .ctl_i    (ctl_r[p*`MMIOP_W +: `MMIOP_W]),
            .dir_i    (dir_r[p*`MMIOP_W +: `MMIOP_W]),
            .dout_i   (dout_r[p*`MMIOP_W +: `MMIOP_W]),
            // even ports carry address bits 7:0, odd ports 15:8
            .addr_i   (ad_lat[(p%2)*`MMIOP_W +: `MMIOP_W]),
            .mc_i     (gla_out_i[p*`MMIOP_W +: `MMIOP_W]),
            .mc_oe_i  (pla_oe_i[p*`MMIOP_W +: `MMIOP_W]),
            .dp_en_i  (dp_en & (p == `MMIOP_PORT_C)),
            .dp_dat_i (host_dat_i),
            .dp_oe_i  (host_dat_oe_i),
            .pin_o    (pin_o[p*`MMIOP_W +: `MMIOP_W]),
            .pin_oe_o (pin_oe_o[p*`MMIOP_W +: `MMIOP_W])
         );
      end
   endgenerate

endmodule // mmiop_top

/* testbench/mmiop_chk.sv */
// checker for the five-port i/o block: bus answer, logic-mode pins,
// address taps; sees only the top module's ports
`timescale 1ns/10ps
module mmiop_chk #(
   parameter [39:0] PLD_MODE = 40'h0
) (
   // clock, reset, bus
   input wire        clk_i, rst_i, ce_i, cyc_i, stb_i, ack_o,
   input wire [31:0] dat_o,
   // taps and pins
   input wire        address_latch_strobe_i,
   input wire [7:0]  dla_addr_o,
   input wire [15:0] pla_addr_o,
   input wire [39:0] pla_in_o, gla_out_i, pla_oe_i, pin_i, pin_o, pin_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_resp_a: assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (ce_i && !ack_o && !(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   rd_pad_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   pld_out_a: assert property ($past(ce_i) && !$past(rst_i) |->
      ((pin_o ^ $past(gla_out_i)) & PLD_MODE) == 40'h0)
      else $error("logic pin not driven by macrocell");
   pld_oe_a: assert property ($past(ce_i) && !$past(rst_i) |->
      ((pin_oe_o ^ $past(pla_oe_i)) & PLD_MODE) == 40'h0)
      else $error("logic pin enable wrong");
   tap_copy_a: assert property ($past(ce_i) && !$past(rst_i) |->
      pla_in_o == $past(pin_i) && pla_addr_o == $past(pin_i[31:16]))
      else $error("array input taps wrong");
   lat_hold_a: assert property ((ce_i && !address_latch_strobe_i)[*3]
      |-> $stable(dla_addr_o)) else $error("address latch moved");
   rst_quiet_a: assert property (disable iff (1'b0) rst_i |=>
      !ack_o && pin_oe_o == 40'h0) else $error("outputs active in reset");
   cover property (ack_o);
   cover property (address_latch_strobe_i ##1 !address_latch_strobe_i);
   cover property ((pin_oe_o & PLD_MODE) != 40'h0);
endmodule // mmiop_chk

bind mmiop_top mmiop_chk #(.PLD_MODE(PLD_MODE)) mmiop_chk_inst (
   .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o, .dat_o,
   .address_latch_strobe_i, .dla_addr_o, .pla_addr_o, .pla_in_o,
   .gla_out_i, .pla_oe_i, .pin_i, .pin_o, .pin_oe_o);

/* testbench/mmiop_host_model.sv */
// host side of the multiplexed address/data bus: address plus strobe;
// assumes put_addr is called just after a rising clock edge
`timescale 1ns/10ps
module mmiop_host_model (
   // clock
   input  wire        clk_i,
   // multiplexed bus
   output reg  [15:0] ad_o,
   output reg         als_o
);
   initial begin
      ad_o  = 16'h0000;
      als_o = 1'b0;
   end
   // released bus shows the inverse, so a latch that follows it shows up
   task put_addr(input [15:0] a);
      begin
         ad_o  <= a;
         als_o <= 1'b1;
         @(posedge clk_i);
         ad_o  <= ~a;
         als_o <= 1'b0;
      end
   endtask
endmodule // mmiop_host_model

/* testbench/tb_mmiop_top.sv */
// bench for the five-port i/o block: wishbone tasks, shadow registers,
// pin expectations; pins resolve from enables and external levels
`timescale 1ns/10ps
module tb_mmiop_top;
   localparam [39:0] PLDM = 40'h00_0000_0f00;
   localparam [39:0] GLA  = 40'h3c_96_a5_5a_c3;
   localparam [39:0] PLOE = 40'h00_0000_0500;
   reg         clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, hit_r;
   reg  [39:0] gla_out_i, pla_oe_i;
   reg  [3:0]  sel_i;
   reg  [31:0] adr_i, dat_i;
   reg  [39:0] ext_r;
   reg  [15:0] lat_m;
   reg  [7:0]  ctl_m [0:4], dir_m [0:4], dout_m [0:4], q;
   wire [31:0] dat_o;
   wire        ack_o, als;
   wire [15:0] ad;
   wire [7:0]  dla_addr_o;
   wire [39:0] pin_i, pin_o, pin_oe_o;
   integer     failures, num_checks, i;
   assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_r);
   mmiop_top #(.PLD_MODE(PLDM), .MUX_BUS(1'b1), .DATA_PORT_C(1'b1))
      mmiop_top_inst (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .io_block_select_i(hit_r),
      .ad_i(ad),
      .address_latch_strobe_i(als), .host_dat_i(8'h00),
      .host_dat_oe_i(1'b0), .host_dat_o(), .gla_out_i,
      .pla_oe_i, .pla_in_o(), .dla_addr_o, .pla_addr_o(), .pin_i,
      .pin_o, .pin_oe_o);
   mmiop_host_model mmiop_host_model_inst (.clk_i, .ad_o(ad), .als_o(als));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, failures);
         if (failures == 0 && num_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      #200000;
      failures = failures + 1;
      give_verdict;
   end
   task chk(input [39:0] got, input [39:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // one classic cycle; entered just after a rising edge
   task wb(input w, input [7:0] idx, input [7:0] d);
      integer n;
      begin
         n = 0;
         {cyc_i, stb_i, we_i} <= {2'b11, w};
         adr_i <= {22'h0, idx, 2'b00};
         dat_i <= {24'h0, d};
         do begin
            @(posedge clk_i);
            n = n + 1;
         end while (ack_o !== 1'b1 && n < 20);
         if (n >= 20) begin
            failures = failures + 1;
            give_verdict;
         end
         q = dat_o[7:0];
         {cyc_i, stb_i, we_i} <= 3'b000;
         @(posedge clk_i);
      end
   endtask
   task rd(input [7:0] idx, input [7:0] exp);
      begin
         wb(1'b0, idx, 8'h00);
         chk(q, exp);
      end
   endtask
   function [7:0] base(input integer p);
      base = (p < 2) ? p : (p < 4) ? 8'h0e + p : 8'h20;
   endfunction
   task setr(input integer p, input [7:0] k, input [7:0] v);
      begin
         wb(1'b1, base(p) + k, v);
         if (k == 8'h02) ctl_m[p] = v;
         if (k == 8'h04) dout_m[p] = v;
         if (k == 8'h06) dir_m[p] = v;
      end
   endtask
   // pins two edges behind the address strobe, then data-in of every port
   task pins;
      reg [7:0] pm, o, e;
      integer   p;
      begin
         repeat (2) @(posedge clk_i);
         for (p = 0; p < 5; p = p + 1) begin
            pm = PLDM[p*8+:8];
            e = (pm & PLOE[p*8+:8]) | (~pm & dir_m[p]);
            o = (pm & GLA[p*8+:8]) | (~pm & ctl_m[p] & dout_m[p])
              | (~pm & ~ctl_m[p] & (p % 2 ? lat_m[15:8] : lat_m[7:0]));
            chk(pin_oe_o[p*8+:8], e);
            chk(pin_o[p*8+:8] & e, o & e);
            rd(base(p), (e & o) | (~e & ext_r[p*8+:8]));
         end
      end
   endtask
   initial begin
      {rst_i, cyc_i, stb_i, we_i, hit_r, sel_i} = 9'h111;
      ce_i = 1'b1;
      gla_out_i = GLA;
      pla_oe_i = PLOE;
      {adr_i, dat_i} = 64'h0;
      ext_r = 40'h5a_3c_e1_96_0f;
      {failures, num_checks, lat_m} = 0;
      for (i = 0; i < 5; i = i + 1)
         {ctl_m[i], dir_m[i], dout_m[i]} = 24'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
         rd(base(i) + 8'h02, 8'h00);
         rd(base(i) + 8'h04, 8'h00);
         rd(base(i) + 8'h06, 8'h00);
      end
      pins;
      for (i = 0; i < 5; i = i + 1) begin
         setr(i, 8'h02, 8'hf0 ^ i[7:0]);
         setr(i, 8'h04, 8'ha5 + i[7:0]);
         setr(i, 8'h06, 8'h3c << i);
         rd(base(i) + 8'h04, dout_m[i]);
         rd(base(i) + 8'h06, dir_m[i]);
      end
      mmiop_host_model_inst.put_addr(16'hc35a);
      lat_m = 16'hc35a;
      pins;
      setr(2, 8'h04, 8'h0f);
      pins;
      for (i = 0; i < 5; i = i + 1) begin
         setr(i, 8'h02, 8'h00);
         setr(i, 8'h06, 8'hff);
      end
      mmiop_host_model_inst.put_addr(16'h9e17);
      lat_m = 16'h9e17;
      pins;
      // a strobe while the enable is low must not reach the latch
      ce_i <= 1'b0;
      mmiop_host_model_inst.put_addr(16'h1234);
      ce_i <= 1'b1;
      pins;
      hit_r <= 1'b0;
      wb(1'b1, 8'h06, 8'h00);
      rd(8'h06, 8'h00);
      hit_r <= 1'b1;
      sel_i <= 4'h0;
      wb(1'b1, 8'h06, 8'h00);
      sel_i <= 4'h1;
      rd(8'h06, 8'hff);
      wb(1'b1, 8'h0b, 8'hff);
      rd(8'h0b, PLDM[15:8]);
      rd(8'h0d, GLA[15:8]);
      rd(8'h2c, GLA[39:32]);
      rd(8'h08, 8'h00);
      rd(8'h40, 8'h00);
      setr(0, 8'h06, 8'h00);
      ext_r[7:0] <= 8'h6b;
      @(posedge clk_i);
      mmiop_host_model_inst.put_addr(16'h0000);
      ext_r[7:0] <= 8'h94;
      repeat (2) @(posedge clk_i);
      chk(dla_addr_o, 8'h6b);
      repeat (3) @(posedge clk_i);
      chk(dla_addr_o, 8'h6b);
      give_verdict;
   end
endmodule // tb_mmiop_top
